// ==== common/msq_pkg.sv ====
// shared constants and carriers for the motion sleep sequencer
// assumes a single 25 MHz clock domain and firmware-held configuration
package msq_pkg;
  localparam int MSQ_CLK_KHZ = 25000;
  localparam int MSQ_TICK_TIME_US = 1000;
  localparam int MSQ_TICK_CYCLES = MSQ_TICK_TIME_US * MSQ_CLK_KHZ / 1000;
  localparam int MSQ_CHECK_TIME_US = 2300;
  localparam int MSQ_CHECK_CYCLES = MSQ_CHECK_TIME_US * MSQ_CLK_KHZ / 1000;
  localparam int MSQ_LEVELS = 4;
  localparam int MSQ_FIELD_W = 16;
  localparam int MSQ_TIMER_W = 20;
  localparam logic [1:0] MSQ_LEVEL_RST = 2'h0;
  localparam logic [1:0] MSQ_LEVEL_DEEPEST = 2'h3;
  localparam logic [MSQ_FIELD_W-1:0] MSQ_DWELL_RST = 16'h0000;

  // gray codes along track -> sleep -> check -> back
  typedef enum logic [1:0] {
    MSQ_TRACK = 2'h0,
    MSQ_SLEEP = 2'h1,
    MSQ_CHECK = 2'h3,
    MSQ_INACT = 2'h2
  } msq_state_type;

  typedef struct packed {
    logic [MSQ_FIELD_W-1:0] sleep_ms;
    logic [MSQ_FIELD_W-1:0] threshold;
    logic [MSQ_FIELD_W-1:0] dwell_ms;
  } msq_level_cfg_type;

  typedef struct packed {
    msq_state_type state;
    logic [1:0] level;
    logic laser_on;
    logic detector_on;
  } msq_status_type;
endpackage

// ==== design/msq_countdown.sv ====
// reloadable down counter that pulses once when it runs out
// assumes load and step come from logic on the same clock
module msq_countdown
  import msq_pkg::*;
#(
  parameter int W = MSQ_TIMER_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic step,
  output logic done
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic expire_d;

  // elaboration guard: a one-bit counter cannot tell a reload from expiry
  if (W < 2) begin : g_bad_width
    $error("msq_countdown: W must be at least 2");
  end

  // a zero load expires at once so a zero interval never stalls
  assign expire_d = load ? (load_val == '0) : (step && count_q == W'(1));
  assign count_d = load ? load_val :
                   (step && count_q != '0) ? count_q - W'(1) : count_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_q <= '0;
      done <= 1'b0;
    end else begin
      count_q <= count_d;
      done <= expire_d;
    end
  end
endmodule

// ==== design/msq_sequencer.sv ====
// power-mode sequencer: tracking, inactive and four sleep levels
// assumes motion reports and configuration arrive on mclk from on-chip logic
module msq_sequencer
  import msq_pkg::*;
#(
  parameter int TICK_CYCLES = MSQ_TICK_CYCLES,
  parameter int CHECK_CYCLES = MSQ_CHECK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic power_save_en,
  input wire logic [MSQ_FIELD_W-1:0] track_idle_ms,
  input wire msq_level_cfg_type level_cfg [MSQ_LEVELS],
  input wire logic inactive_req,
  input wire logic [MSQ_FIELD_W-1:0] inactive_ms,
  input wire logic motion_valid,
  input wire logic [MSQ_FIELD_W-1:0] motion_amount,
  output msq_status_type status,
  output logic wake_irq
);
  localparam logic [MSQ_TIMER_W-1:0] CHECK_LOAD = MSQ_TIMER_W'(CHECK_CYCLES - 1);

  // elaboration guards: the tick needs at least two cycles and the check window must fit the shared timer width
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("msq_sequencer: TICK_CYCLES must be at least 2");
  end
  if (CHECK_CYCLES < 2 || CHECK_CYCLES > (1 << MSQ_TIMER_W)) begin : g_bad_check
    $error("msq_sequencer: CHECK_CYCLES out of range");
  end

  function automatic logic reaches(input logic [MSQ_FIELD_W-1:0] amount,
                                   input logic [MSQ_FIELD_W-1:0] thr);
    reaches = amount >= thr;
  endfunction

  msq_state_type state_q;
  msq_state_type state_d;
  logic [1:0] level_q;
  logic [1:0] level_d;
  logic [MSQ_FIELD_W-1:0] dwell_q;
  logic [MSQ_FIELD_W-1:0] dwell_d;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic ival_done;
  logic chk_done;
  logic ival_load;
  logic [MSQ_TIMER_W-1:0] ival_val;
  logic chk_load;
  logic hit_track;
  logic hit_level;
  logic dwell_hit;
  logic in_sleep;
  logic sensing;
  logic wake_d;
  logic state_chg;

  // free-running millisecond tick; timers may run up to one tick short
  assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);
  always_ff @(posedge mclk) begin
    if (!rst_n) tick_cnt_q <= '0;
    else tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h1;
  end

  // motion only counts while the laser and detector are powered
  assign sensing = state_q == MSQ_TRACK || state_q == MSQ_CHECK;
  assign hit_track = sensing && motion_valid &&
                     reaches(motion_amount, level_cfg[MSQ_LEVEL_RST].threshold);
  assign hit_level = sensing && motion_valid &&
                     reaches(motion_amount, level_cfg[level_q].threshold);
  assign in_sleep = state_q == MSQ_SLEEP || state_q == MSQ_CHECK;
  assign dwell_hit = in_sleep && level_q != MSQ_LEVEL_DEEPEST &&
                     dwell_q >= level_cfg[level_q].dwell_ms;

  // next mode; the engine walks the levels by itself
  always_comb begin
    state_d = state_q;
    wake_d = 1'b0;
    case (state_q)
      MSQ_TRACK: begin
        if (inactive_req) state_d = MSQ_INACT;
        else if (power_save_en && ival_done && !hit_track) state_d = MSQ_SLEEP;
      end
      MSQ_SLEEP: begin
        if (!power_save_en) state_d = MSQ_TRACK;
        else if (inactive_req) state_d = MSQ_INACT;
        else if (ival_done) state_d = MSQ_CHECK;
      end
      MSQ_CHECK: begin
        if (!power_save_en) state_d = MSQ_TRACK;
        else if (hit_level) state_d = MSQ_TRACK;
        else if (inactive_req) state_d = MSQ_INACT;
        else if (chk_done) state_d = MSQ_SLEEP;
      end
      MSQ_INACT: begin
        if (ival_done) begin
          state_d = MSQ_TRACK;
          wake_d = 1'b1;
        end
      end
      default: state_d = MSQ_TRACK;
    endcase
  end

  // level and dwell: restart shallow on every entry into sleep from tracking
  assign state_chg = state_d != state_q;
  assign level_d = (state_d == MSQ_TRACK || state_d == MSQ_INACT) ? MSQ_LEVEL_RST :
                   (state_q == MSQ_TRACK) ? MSQ_LEVEL_RST :
                   dwell_hit ? level_q + 2'h1 : level_q;
  assign dwell_d = (state_q == MSQ_TRACK || state_d == MSQ_TRACK || dwell_hit) ? MSQ_DWELL_RST :
                   (in_sleep && tick && dwell_q != '1) ? dwell_q + 16'h1 : dwell_q;

  // one interval timer serves idle wait, sleep interval and inactive wake
  assign ival_load = (state_chg && state_d != MSQ_CHECK) ||
                     (state_q == MSQ_TRACK && hit_track);
  assign ival_val = (state_d == MSQ_SLEEP) ? MSQ_TIMER_W'(level_cfg[level_d].sleep_ms) :
                    (state_d == MSQ_INACT) ? MSQ_TIMER_W'(inactive_ms) :
                    MSQ_TIMER_W'(track_idle_ms);
  assign chk_load = state_chg && state_d == MSQ_CHECK;

  msq_countdown #(.W(MSQ_TIMER_W)) u_ival (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(ival_load),
    .load_val(ival_val),
    .step(tick),
    .done(ival_done)
  );

  // check window counts clock cycles, not ticks, for an exact length
  msq_countdown #(.W(MSQ_TIMER_W)) u_check (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(chk_load),
    .load_val(CHECK_LOAD),
    .step(1'b1),
    .done(chk_done)
  );

  // status outputs come from flops fed by the next-state values
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= MSQ_TRACK;
      level_q <= MSQ_LEVEL_RST;
      dwell_q <= MSQ_DWELL_RST;
      status <= '{state: MSQ_TRACK, level: MSQ_LEVEL_RST, laser_on: 1'b1, detector_on: 1'b1};
      wake_irq <= 1'b0;
    end else begin
      state_q <= state_d;
      level_q <= level_d;
      dwell_q <= dwell_d;
      status.state <= state_d;
      status.level <= level_d;
      status.laser_on <= state_d == MSQ_TRACK || state_d == MSQ_CHECK;
      status.detector_on <= state_d == MSQ_TRACK || state_d == MSQ_CHECK;
      wake_irq <= wake_d;
    end
  end

  // helper: length of the current check window, for the checks below
  logic [MSQ_TIMER_W:0] chk_len_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) chk_len_q <= '0;
    else if (state_q == MSQ_CHECK) chk_len_q <= chk_len_q + 1'b1;
    else chk_len_q <= '0;
  end

  sequence s_check_miss;
    state_q == MSQ_CHECK && power_save_en && chk_done && !hit_level && !inactive_req;
  endsequence

  sequence s_back_asleep;
    state_q == MSQ_SLEEP && !status.laser_on;
  endsequence

  a_disabled_no_sleep: assert property (@(posedge mclk) disable iff (!rst_n)
    !power_save_en && state_q != MSQ_INACT && !inactive_req |=> state_q == MSQ_TRACK)
    else $error("sleep state held while power saving disabled");

  a_check_wakes: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == MSQ_CHECK && power_save_en && hit_level
    |=> state_q == MSQ_TRACK && level_q == MSQ_LEVEL_RST && status.laser_on)
    else $error("motion at check did not resume tracking");

  a_check_misses: assert property (@(posedge mclk) disable iff (!rst_n)
    s_check_miss |=> s_back_asleep)
    else $error("quiet check did not return to sleep");

  a_check_length: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == MSQ_SLEEP && $past(state_q) == MSQ_CHECK
    |-> chk_len_q == (MSQ_TIMER_W + 1)'(CHECK_CYCLES))
    else $error("check window length wrong");

  a_level_advance: assert property (@(posedge mclk) disable iff (!rst_n)
    dwell_hit && state_d != MSQ_TRACK && state_d != MSQ_INACT
    |=> level_q == $past(level_q) + 2'h1 && dwell_q == MSQ_DWELL_RST)
    else $error("dwell elapsed without deeper level");

  a_level_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == MSQ_TRACK && state_d == MSQ_SLEEP |=> level_q == MSQ_LEVEL_RST)
    else $error("sleep entry not at shallowest level");

  a_inactive_wake: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == MSQ_INACT && ival_done |=> wake_irq && state_q == MSQ_TRACK ##1 !wake_irq)
    else $error("inactive timer did not wake with interrupt");

  a_laser_follows: assert property (@(posedge mclk) disable iff (!rst_n)
    status.laser_on == (state_q == MSQ_TRACK || state_q == MSQ_CHECK) &&
    status.detector_on == status.laser_on && status.state == state_q)
    else $error("laser power does not match mode");

  a_sleep_to_check: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == MSQ_SLEEP && power_save_en && !inactive_req && ival_done
    |=> state_q == MSQ_CHECK && status.laser_on)
    else $error("sleep interval end did not start a check");
endmodule

// ==== bench/msq_sequencer_tb_top.sv ====
// self-checking bench for the motion sleep sequencer
// assumes msq_pkg is compiled first and the design checks its own assertions
module msq_sequencer_tb_top
  import msq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // short tick and check lengths keep the run small
  localparam int TICK = 4;
  localparam int CHK = 8;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic power_save_en = 1'b0;
  logic inactive_req = 1'b0;
  logic motion_valid = 1'b0;
  logic [15:0] track_idle_ms = 16'h0002;
  logic [15:0] inactive_ms = 16'h0003;
  logic [15:0] motion_amount = 16'h0000;
  logic [15:0] thr;
  msq_level_cfg_type level_cfg [MSQ_LEVELS];
  msq_status_type status;
  logic wake_irq;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  msq_sequencer #(.TICK_CYCLES(TICK), .CHECK_CYCLES(CHK)) dut (
    .mclk(mclk), .rst_n(rst_n), .power_save_en(power_save_en),
    .track_idle_ms(track_idle_ms), .level_cfg(level_cfg),
    .inactive_req(inactive_req), .inactive_ms(inactive_ms),
    .motion_valid(motion_valid), .motion_amount(motion_amount),
    .status(status), .wake_irq(wake_irq));

  always #20 mclk = ~mclk;

  task automatic test_done;
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // a hang is cut off well past the longest expected sequence
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic step(input int k = 1);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic wait_st(input msq_state_type s, input int lim);
    int i;
    i = 0;
    while (status.state !== s && i < lim) begin
      step();
      i++;
    end
  endtask

  task automatic hit(input logic [15:0] amt);
    motion_amount = amt;
    motion_valid = 1'b1;
    step();
    motion_valid = 1'b0;
  endtask

  // a check wakes only when the amount reaches the level threshold
  function automatic msq_state_type after_check(input logic [15:0] amt, input logic [15:0] t);
    return (amt >= t) ? MSQ_TRACK : MSQ_CHECK;
  endfunction

  initial begin
    void'($urandom(34));
    for (int i = 0; i < MSQ_LEVELS; i++) begin
      level_cfg[i] = '{sleep_ms: 16'h0001, threshold: 16'($urandom_range(16, 255)),
                       dwell_ms: 16'h0003};
    end
    // long dwell at level one so the threshold test sees one level only
    level_cfg[1].dwell_ms = 16'h0040;
    step(16);
    chk(16'(status), 16'h0003);
    chk(16'(wake_irq), 16'h0000);
    rst_n = 1'b1;
    // saving off: no sleep however long the idle spell
    hit(level_cfg[0].threshold);
    step(60);
    chk(16'(status.state), 16'(MSQ_TRACK));
    // saving on: idle spell leads into sleep at level zero, laser off
    power_save_en = 1'b1;
    hit(level_cfg[0].threshold);
    wait_st(MSQ_SLEEP, 40);
    chk(16'(status.state), 16'(MSQ_SLEEP));
    chk(16'(status.level), 16'h0000);
    chk(16'(status.laser_on), 16'h0000);
    chk(16'(status.detector_on), 16'h0000);
    wait_st(MSQ_CHECK, 20);
    chk(16'(status.state), 16'(MSQ_CHECK));
    chk(16'(status.laser_on), 16'h0001);
    n = 0;
    while (status.state === MSQ_CHECK && n < 100) begin
      step();
      n++;
    end
    chk(16'(n), 16'(CHK));
    chk(16'(status.state), 16'(MSQ_SLEEP));
    // dwell runs out with no motion: one level deeper
    n = 0;
    while (status.level !== 2'h1 && n < 200) begin
      step();
      n++;
    end
    chk(16'(status.level), 16'h0001);
    // below the threshold keeps checking, at the threshold wakes fully
    // start from a fresh check window so the hits land well inside it
    wait_st(MSQ_SLEEP, 40);
    wait_st(MSQ_CHECK, 40);
    thr = level_cfg[status.level].threshold;
    motion_amount = 16'($urandom_range(0, thr - 1));
    hit(motion_amount);
    chk(16'(status.state), 16'(after_check(motion_amount, thr)));
    hit(thr);
    chk(16'(status.state), 16'(after_check(thr, thr)));
    chk(16'(status.level), 16'h0000);
    // inactive mode: laser off, timer wakes with a single pulse
    inactive_req = 1'b1;
    step();
    inactive_req = 1'b0;
    chk(16'(status.state), 16'(MSQ_INACT));
    chk(16'(status.laser_on), 16'h0000);
    chk(16'(status.detector_on), 16'h0000);
    n = 0;
    while (wake_irq !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    chk(16'(wake_irq), 16'h0001);
    chk(16'(status.state), 16'(MSQ_TRACK));
    step();
    chk(16'(wake_irq), 16'h0000);
    test_done();
  end
endmodule
